// ### inc/bc_pkg.sv
package bc_pkg;

    // port count and register layout
    localparam int NUM_PORTS = 2;
    localparam logic [7:0] BC_ENABLE_ADDR = 8'hD0;
    localparam int BC_EN_P1_BIT = 1;
    localparam int BC_EN_P2_BIT = 2;
    localparam logic [1:0] BC_ENABLE_RESET = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // configuration select encodings
    localparam logic CFG_SEL_STRAPS = 1'b0;
    localparam logic CFG_SEL_SMBUS = 1'b1;

    // serial management slave address, used by the bus engine outside
    localparam logic [6:0] SMBUS_SLAVE_ADDR = 7'h2C;

    // strap hold after reset release, rounded up to whole cycles
    localparam int CLK_PERIOD_PS = 4000;
    localparam int STRAP_HOLD_PS = 16700;
    localparam int STRAP_HOLD_CYC = (STRAP_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STRAP_CNT_W = 4;

endpackage

// ### inc/strap_if.sv
`timescale 1ns/1ps
`default_nettype none

// sampled configuration handed from the strap sampler to the core
interface strap_if;
    logic cfg_sel;
    logic charge_strap_p1;
    logic led_strap;
    logic done;

    modport sampler (output cfg_sel, output charge_strap_p1, output led_strap, output done);
    modport core (input cfg_sel, input charge_strap_p1, input led_strap, input done);
endinterface

`default_nettype wire

// ### design/strap_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module strap_sampler (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // raw strap pins
    input wire logic cfg_sel_pin_in,
    input wire logic charge_strap_pin_in,
    input wire logic led_strap_pin_in,
    // sampled results
    strap_if.sampler cfg
);

    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic [bc_pkg::STRAP_CNT_W-1:0] cnt_q;
    logic done_q;
    logic cfg_sel_q;
    logic charge_q;
    logic led_q;

    // two-flop synchronisers on the strap pins
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {led_strap_pin_in, charge_strap_pin_in, cfg_sel_pin_in};
            pin_sync_q <= pin_meta_q;
        end
    end

    // hold-time wait after release, then one capture; straps stay still after
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            done_q <= 1'b0;
            cfg_sel_q <= 1'b0;
            charge_q <= 1'b0;
            led_q <= 1'b0;
        end else if (!done_q) begin
            if (cnt_q == bc_pkg::STRAP_CNT_W'(bc_pkg::STRAP_HOLD_CYC)) begin
                done_q <= 1'b1;
                cfg_sel_q <= pin_sync_q[0];
                // straps count only in strap mode; high gives 1, low gives 0
                charge_q <= pin_sync_q[1] & (pin_sync_q[0] == bc_pkg::CFG_SEL_STRAPS); // see RULE9 RULE10
                led_q <= pin_sync_q[2] & (pin_sync_q[0] == bc_pkg::CFG_SEL_STRAPS); // see RULE9 RULE10
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign cfg.cfg_sel = cfg_sel_q;
    assign cfg.charge_strap_p1 = charge_q;
    assign cfg.led_strap = led_q;
    assign cfg.done = done_q;

endmodule

`default_nettype wire

// ### design/bc_port_power.sv
// What this block does
// RULE1 - power charging ports right after configuration completes
// RULE2 - no wait for enumeration or vbus detect
// RULE3 - over-current turns that port's power off
// RULE4 - tripped port restarts only by host or reset
// RULE5 - report persisting over-current once attached to host
// RULE6 - enable register: bit 1 port 1, bit 2 port 2
// RULE7 - set enable asserts matching port power output
// RULE8 - enable from port 1 strap or register
// RULE9 - straps sampled only when strap mode selected
// RULE10 - strap high gives 1, low gives 0
// RULE11 - shared LED polarity follows sampled strap value
// RULE12 - select 1 means register config, 0 means straps
// RULE13 - unused enable bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module bc_port_power (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // configuration pins
    input wire logic cfg_sel_in,
    input wire logic charge_enable_strap_p1_in,
    input wire logic led_strap_in,
    // register port from the serial management slave engine
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic smbus_load_done_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // hub core state and host port commands
    input wire logic hub_configured_in,
    input wire logic [2:1] host_power_set_in,
    input wire logic [2:1] host_power_clr_in,
    input wire logic [2:1] host_oc_clear_in,
    input wire logic led_on_in,
    // port power switches and over-current detectors
    input wire logic [2:1] over_current_n_in,
    output logic [2:1] port_power_out,
    output logic [2:1] port_power_oe_out,
    output logic [2:1] oc_status_out,
    // shared LED pin and configuration state
    output logic led_out,
    output logic led_oe_out,
    output logic cfg_done_out
);

    strap_if straps ();

    logic [2:1] oc_meta_q;
    logic [2:1] oc_sync_q;
    logic [2:1] charge_en_q;
    logic load_seen_q;
    logic cfg_done_q;
    logic [2:1] tripped_q;
    logic [2:1] host_pwr_q;
    logic [2:1] pwr_q;
    logic [2:1] oc_stat_q;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic led_q;
    logic led_oe_q;
    logic smbus_mode;
    logic [2:1] oc_now;

    // strap capture after reset release
    strap_sampler u_sampler (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .cfg_sel_pin_in(cfg_sel_in),
        .charge_strap_pin_in(charge_enable_strap_p1_in),
        .led_strap_pin_in(led_strap_in),
        .cfg(straps)
    );

    // register writes only land once select has picked the bus; reads answer in either mode
    assign smbus_mode = straps.done & (straps.cfg_sel == bc_pkg::CFG_SEL_SMBUS); // see RULE12

    // over-current detectors are off-chip, so synchronise first
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oc_meta_q <= 2'h3;
            oc_sync_q <= 2'h3;
        end else begin
            oc_meta_q <= over_current_n_in;
            oc_sync_q <= oc_meta_q;
        end
    end

    assign oc_now = ~oc_sync_q;

    // bus mode waits for the code load before calling configuration done
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_seen_q <= 1'b0;
        end else if (smbus_mode && smbus_load_done_in) begin
            load_seen_q <= 1'b1;
        end
    end

    // configuration complete; no dependence on enumeration or vbus detect
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_done_q <= 1'b0;
        end else if (straps.done && (!smbus_mode || load_seen_q)) begin
            cfg_done_q <= 1'b1; // see RULE1 RULE2 RULE12
        end
    end

    // charging enables: strap for port 1 only, or written over the bus
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            charge_en_q <= bc_pkg::BC_ENABLE_RESET;
        end else if (straps.done && !smbus_mode && !cfg_done_q) begin
            charge_en_q <= {1'b0, straps.charge_strap_p1}; // see RULE8
        end else if (smbus_mode && reg_wr_in && reg_addr_in == bc_pkg::BC_ENABLE_ADDR) begin
            // only bits 2 and 1 are stored, the rest are dropped
            charge_en_q <= {reg_wdata_in[bc_pkg::BC_EN_P2_BIT],
                            reg_wdata_in[bc_pkg::BC_EN_P1_BIT]}; // see RULE6 RULE8 RULE13
        end
    end

    // register readback, one cycle after the read strobe
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_in;
            if (reg_rd_in) begin
                if (reg_addr_in == bc_pkg::BC_ENABLE_ADDR) begin
                    rdata_q <= {5'h00, charge_en_q, 1'b0}; // see RULE6 RULE13
                end else begin
                    rdata_q <= bc_pkg::UNMAPPED_READ;
                end
            end
        end
    end

    // per-port power, trip and status state
    for (genvar p = 1; p <= bc_pkg::NUM_PORTS; p++) begin : g_port
        // a trip latches until host power-on; reset clears it too
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                tripped_q[p] <= 1'b0;
            end else if (cfg_done_q && oc_now[p]) begin
                tripped_q[p] <= 1'b1; // see RULE4
            end else if (host_power_set_in[p]) begin
                tripped_q[p] <= 1'b0; // see RULE4
            end
        end

        // host power state; an over-current also drops it
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                host_pwr_q[p] <= 1'b0;
            end else if (oc_now[p] || host_power_clr_in[p]) begin
                host_pwr_q[p] <= 1'b0;
            end else if (host_power_set_in[p]) begin
                host_pwr_q[p] <= 1'b1; // see RULE4
            end
        end

        // power is on for charging or host request, off on any over-current
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                pwr_q[p] <= 1'b0;
            end else begin
                pwr_q[p] <= cfg_done_q & ~oc_now[p] & ~tripped_q[p]
                            & (charge_en_q[p] | host_pwr_q[p]); // see RULE1 RULE3 RULE7
            end
        end

        // sticky status seen by the host; a new event beats the clear
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                oc_stat_q[p] <= 1'b0;
            end else if (hub_configured_in && oc_now[p]) begin
                oc_stat_q[p] <= 1'b1; // see RULE5
            end else if (host_oc_clear_in[p]) begin
                oc_stat_q[p] <= 1'b0;
            end
        end
    end

    // pins stay undriven while straps may still be read
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            port_power_oe_out <= 2'h0;
        end else begin
            port_power_oe_out <= {cfg_done_q, cfg_done_q};
        end
    end

    // strap pulled high means the LED hangs to supply: drive active low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            led_q <= 1'b0;
            led_oe_q <= 1'b0;
        end else begin
            led_q <= led_on_in ^ straps.led_strap; // see RULE11
            led_oe_q <= straps.done;
        end
    end

    assign port_power_out = pwr_q;
    assign oc_status_out = oc_stat_q;
    assign reg_rdata_out = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign led_out = led_q;
    assign led_oe_out = led_oe_q;
    assign cfg_done_out = cfg_done_q;

endmodule

`default_nettype wire

// ### verif/bc_checker.sv
`timescale 1ns/1ps
`default_nettype none

module bc_checker (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    // hub state and port side
    input wire logic hub_configured_in,
    input wire logic [2:1] host_power_set_in,
    input wire logic [2:1] over_current_n_in,
    input wire logic [2:1] port_power_out,
    input wire logic [2:1] port_power_oe_out,
    input wire logic [2:1] oc_status_out,
    input wire logic cfg_done_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // sync takes two edges, so the cut lands on the third
    oc_trip_a: assert property (
        $fell(over_current_n_in[1]) && cfg_done_out |-> ##3 !port_power_out[1])
        else $error("port 1 power not cut on over-current");
    power_needs_done_a: assert property (
        port_power_out != 2'h0 |-> cfg_done_out)
        else $error("port power before configuration done");
    power_pins_on_a: assert property (
        $rose(cfg_done_out) |=> port_power_oe_out == 2'h3)
        else $error("power pins not driven after configuration");
    read_answer_a: assert property (
        reg_rd_in |=> reg_rvalid_out)
        else $error("read strobe without valid");
    unmapped_read_a: assert property (
        reg_rd_in && reg_addr_in != bc_pkg::BC_ENABLE_ADDR |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    unused_bits_a: assert property (
        reg_rd_in |=> reg_rdata_out[7:3] == 5'h00 && !reg_rdata_out[0])
        else $error("unused enable bits not zero");
    oc_report_a: assert property (
        ($rose(oc_status_out[1]) || $rose(oc_status_out[2])) |-> $past(hub_configured_in))
        else $error("over-current reported while not enumerated");
    host_restart_a: assert property (
        host_power_set_in[1] && cfg_done_out && over_current_n_in[1]
        && $past(over_current_n_in[1]) && $past(over_current_n_in[1], 2)
        |-> ##2 port_power_out[1])
        else $error("host power-on did not restart port 1");
endmodule

bind bc_port_power bc_checker i_bc_checker (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .hub_configured_in(hub_configured_in),
    .host_power_set_in(host_power_set_in), .over_current_n_in(over_current_n_in),
    .port_power_out(port_power_out), .port_power_oe_out(port_power_oe_out),
    .oc_status_out(oc_status_out), .cfg_done_out(cfg_done_out));

`default_nettype wire

// ### verif/port_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

module port_switch_model (
    // design side
    input wire logic [2:1] power_in,
    input wire logic [2:1] power_oe_in,
    // bench controls
    input wire logic [2:1] short_in,
    input wire logic strap_pull_in,
    // pins back to the design
    output logic [2:1] over_current_n_out,
    output logic strap_p1_out
);
    // a short only trips while the switch feeds it; flag is pulled up otherwise
    assign over_current_n_out = ~(short_in & power_in & power_oe_in);
    // shared pin shows its strap resistor until the design drives it
    assign strap_p1_out = power_oe_in[1] ? power_in[1] : strap_pull_in;
endmodule

`default_nettype wire

// ### verif/battery_charge_port_power_tb.sv
`timescale 1ns/1ps
`default_nettype none

module battery_charge_port_power_tb;
    logic clk_in = 1'b0, rst_n_in = 1'b0, cfg_sel = 1'b0, strap_pull = 1'b0;
    logic led_strap = 1'b0, wr = 1'b0, rd = 1'b0, hub_cfg = 1'b0, led_on = 1'b0;
    logic strap_p1, led, led_oe, done, rvalid;
    logic [7:0] addr = 8'hD0, wdata = 8'h00, rdata;
    logic [2:1] hset = 2'h0, hclr = 2'h0, hoclr = 2'h0, short = 2'h0, ocn, pp, ppoe, ocs;
    // strap rows: strap level, led strap, led request, expected led pin
    logic [3:0] rows [4] = '{4'b0000, 4'b1011, 4'b1101, 4'b0110};
    int fails = 0, total_checks = 0;

    always #2 clk_in = ~clk_in;

    bc_port_power i_bc_port_power (.clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_sel_in(cfg_sel),
        .charge_enable_strap_p1_in(strap_p1), .led_strap_in(led_strap), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .smbus_load_done_in(cfg_sel),
        .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .hub_configured_in(hub_cfg),
        .host_power_set_in(hset), .host_power_clr_in(hclr), .host_oc_clear_in(hoclr),
        .led_on_in(led_on), .over_current_n_in(ocn), .port_power_out(pp),
        .port_power_oe_out(ppoe), .oc_status_out(ocs), .led_out(led), .led_oe_out(led_oe),
        .cfg_done_out(done));
    port_switch_model i_port_switch_model (.power_in(pp), .power_oe_in(ppoe),
        .short_in(short), .strap_pull_in(strap_pull), .over_current_n_out(ocn),
        .strap_p1_out(strap_p1));

    // inputs always move 1 ns after the edge
    task automatic step(int n = 1);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // returns once the power output has had time to follow
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step();
        wr = 1'b0;
        step(2);
    endtask

    task automatic rreg(logic [7:0] a, logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        step();
        // valid stands one cycle only, so look before the next edge
        chk("read valid", 8'h01, {7'h00, rvalid});
        chk("read data", exp, rdata);
        rd = 1'b0;
        step();
    endtask

    // straps held steady from reset until well after sampling
    task automatic boot(logic sel, logic pull, logic ls);
        rst_n_in = 1'b0;
        cfg_sel = sel;
        strap_pull = pull;
        led_strap = ls;
        step(5);
        rst_n_in = 1'b1;
        for (int i = 0; i < 20 && done !== 1'b1; i++) step();
        chk("config done", 8'h01, {7'h00, done});
        step();
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // whole run is about 160 cycles
    initial begin
        #20000;
        fails++;
        close_out();
    end

    initial begin
        foreach (rows[i]) begin
            led_on = rows[i][1];
            boot(1'b0, rows[i][3], rows[i][2]);
            chk("strap power", {7'h00, rows[i][3]}, {6'h00, pp});
            chk("led pin", {6'h00, 1'b1, rows[i][0]}, {6'h00, led_oe, led});
            wreg(8'hD0, 8'h06);
            chk("strap mode write", {7'h00, rows[i][3]}, {6'h00, pp});
            rreg(8'hD0, {6'h00, rows[i][3], 1'b0});
        end
        $display("test strap rows done");
        boot(1'b1, 1'b1, 1'b0);
        chk("bus mode idle", 8'h00, {6'h00, pp});
        rreg(8'hD0, 8'h00);
        wreg(8'hD0, 8'hFF);
        chk("both ports", 8'h03, {6'h00, pp});
        rreg(8'hD0, 8'h06);
        wreg(8'hD0, 8'h04);
        wreg(8'h55, 8'h02);
        chk("port 2 only", 8'h02, {6'h00, pp});
        rreg(8'h55, 8'h00);
        rreg(8'hD0, 8'h04);
        $display("test bus register done");
        wreg(8'hD0, 8'h06);
        short = 2'h2;
        step(3);
        chk("trip port 2", 8'h01, {6'h00, pp});
        short = 2'h0;
        step(8);
        chk("stays tripped", 8'h01, {6'h00, pp});
        chk("no report", 8'h00, {6'h00, ocs});
        hset = 2'h2;
        step();
        hset = 2'h0;
        step(2);
        chk("host restart", 8'h03, {6'h00, pp});
        hub_cfg = 1'b1;
        short = 2'h1;
        step(3);
        chk("trip port 1", 8'h02, {6'h00, pp});
        chk("report port 1", 8'h01, {6'h00, ocs});
        wreg(8'hD0, 8'h06);
        hoclr = 2'h1;
        step();
        hoclr = 2'h0;
        step();
        chk("enable no restart", 8'h02, {6'h00, pp});
        chk("report cleared", 8'h00, {6'h00, ocs});
        hset = 2'h1;
        step();
        hset = 2'h0;
        step(6);
        chk("short persists", 8'h01, {6'h00, ocs});
        $display("test over-current done");
        short = 2'h0;
        boot(1'b1, 1'b0, 1'b0);
        wreg(8'hD0, 8'h06);
        chk("reset restart", 8'h03, {6'h00, pp});
        // a port fed only by host request follows host set and clear
        wreg(8'hD0, 8'h00);
        hset = 2'h2;
        step();
        hset = 2'h0;
        step(2);
        chk("host power only", 8'h02, {6'h00, pp});
        hclr = 2'h2;
        step();
        hclr = 2'h0;
        step(2);
        chk("host power off", 8'h00, {6'h00, pp});
        $display("test reset restart done");
        close_out();
    end
endmodule

`default_nettype wire
